// File: sim/vdc_host.sv
// vdc_host: host microcontroller model on the register port
// assumes one core_clk domain; every strobe changes just after a rising edge
`timescale 1ns/1ps
module vdc_host (
  // clock
  input wire logic core_clk,
  // register port
  output logic [vdc_pkg::ADDR_W-1:0] reg_addr,
  output logic [vdc_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [vdc_pkg::DATA_W-1:0] reg_rdata
);
  import vdc_pkg::*;
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write; callers keep reserved bits at zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // released lines show the inverse, so a stale value cannot pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // one-cycle read; data taken at the following rising edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd
  // poll the execute bit until it clears, bounded so a stuck bit cannot hang
  task automatic poll_mem(output int n);
    logic [7:0] d;
    n = 0;
    d = 8'h80;
    while (d[BIT_MEMWR] !== 1'b0 && n < 16) begin
      rd(OFF_MEMWR, d);
      n++;
    end
  endtask : poll_mem
endmodule : vdc_host

// File: sim/vdc_regs_test.sv
// vdc_regs_test: self-checking bench for the control register bank
// assumes short wait and divider counts; read results checked through a queue
`timescale 1ns/1ps
module vdc_regs_test;
  import vdc_pkg::*;
  localparam int WAIT_CYC = 20;
  localparam int DIV_CYC = 8;
  // version values are arbitrary
  localparam logic [15:0] V_ADDR = 16'h5a01;
  localparam logic [15:0] V_DATA = 16'h0001;
  logic core_clk, rst_n, ce, skip_init_pin, clock_source_select, frame_sync;
  logic alc_bypass_pin_function;
  logic [3:0] general_inputs_a_high, general_inputs_a_low;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, rd_seen;
  logic ready_flag, normal_mode, pcm_out_hiz, speech_in_idle, dsp_enable, alc_bypass;
  logic [5:0] alc_max_gain_db;
  logic [3:0] receive_volume_code, transmit_volume_code, v;
  logic rx_mute, tx_mute, acoustic_gain_bad, line_gain_bad;
  logic signed [5:0] rx_gain_db, tx_gain_db;
  logic [4:0] acoustic_gain_code, line_gain_code;
  logic [15:0] dsp_mem_addr, dsp_mem_rdata, a, d;
  logic [31:0] p;
  logic [7:0] expq[$];
  int num_errors, checks, cyc, n, i, seed;
  vdc_regs #(.INIT_WAIT_CYCLES(WAIT_CYC), .SYNC_DIV_CYCLES(DIV_CYC),
    .ALC_MAXGAIN_ADDR(16'h0000), .VER_ADDR(V_ADDR), .VER_DATA(V_DATA)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .skip_init_pin(skip_init_pin), .clock_source_select(clock_source_select),
    .frame_sync(frame_sync), .alc_bypass_pin_function(alc_bypass_pin_function),
    .general_inputs_a_high(general_inputs_a_high),
    .general_inputs_a_low(general_inputs_a_low), .ready_flag(ready_flag),
    .normal_mode(normal_mode), .pcm_out_hiz(pcm_out_hiz), .speech_in_idle(speech_in_idle),
    .dsp_enable(dsp_enable), .alc_bypass(alc_bypass), .alc_max_gain_db(alc_max_gain_db),
    .receive_volume_code(receive_volume_code), .transmit_volume_code(transmit_volume_code),
    .rx_mute(rx_mute), .tx_mute(tx_mute), .rx_gain_db(rx_gain_db), .tx_gain_db(tx_gain_db),
    .acoustic_gain_code(acoustic_gain_code), .line_gain_code(line_gain_code),
    .acoustic_gain_bad(acoustic_gain_bad), .line_gain_bad(line_gain_bad),
    .dsp_mem_addr(dsp_mem_addr), .dsp_mem_rdata(dsp_mem_rdata));
  vdc_host host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // verdict and end of run
  task automatic complete_run;
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // one comparison, four-state
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // checked read: note the expectation, then read
  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] r;
    expq.push_back(e);
    host_u.rd(ad, r);
  endtask : rchk
  // expected gain: 3 dB steps, mute reported as -24
  function automatic logic [15:0] gain(input logic [3:0] c);
    logic signed [15:0] g;
    g = $signed({{12{c[3]}}, c}) * 16'sd3;
    return (c == VOL_MUTE) ? 16'hffe8 : g;
  endfunction : gain
  // prohibited pga codes lie outside -10..+10 steps
  function automatic logic bad(input logic [4:0] c);
    return ($signed(c) > 5'sd10) || ($signed(c) < -5'sd10);
  endfunction : bad
  // reset value of each offset; unmapped reads zero
  function automatic logic [7:0] rstv(input int k);
    case (k)
      6: return V_ADDR[15:8];
      7: return V_ADDR[7:0];
      8: return V_DATA[15:8];
      9: return V_DATA[7:0];
      default: return RST_CTRL;
    endcase
  endfunction : rstv
  // memory write through the data and address registers, then poll
  task automatic memw(input logic [15:0] ma, input logic [15:0] md);
    host_u.wr(OFF_MADRH, ma[15:8]);
    host_u.wr(OFF_MADRL, ma[7:0]);
    host_u.wr(OFF_MDATH, md[15:8]);
    host_u.wr(OFF_MDATL, md[7:0]);
    host_u.wr(OFF_MEMWR, 8'h80);
    rchk(OFF_MEMWR, 8'h80);
    host_u.poll_mem(n);
    chk(16'(n >= 1 && n <= 2), 16'h1);
  endtask : memw
  // monitor: a read result stands in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_seen && expq.size() > 0) begin
      chk(16'(reg_rdata), 16'(expq.pop_front()));
    end
    rd_seen <= reg_rd;
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("ERROR %0t: run timed out", $time);
      complete_run();
    end
  end
  // main sequence
  initial begin
    seed = 32'h5fe7;
    rst_n = 1'b0;
    ce = 1'b1;
    skip_init_pin = 1'b0;
    clock_source_select = 1'b1;
    frame_sync = 1'b0;
    alc_bypass_pin_function = 1'b0;
    general_inputs_a_high = 4'h0;
    general_inputs_a_low = 4'h0;
    dsp_mem_addr = 16'h0000;
    rd_seen = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk(OFF_STATUS, 8'h00);
    // wait for ready before any setup
    n = 3;
    while (ready_flag !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk(16'(n >= WAIT_CYC && n <= WAIT_CYC + 4), 16'h1);
    chk({12'h0, pcm_out_hiz, speech_in_idle, dsp_enable, normal_mode}, 16'hc);
    chk(16'(alc_max_gain_db), 16'h1b);
    for (i = 0; i < 12; i++) rchk(8'(i), (i == 10) ? 8'h80 : rstv(i));
    // every volume code on both paths
    for (i = 0; i < 16; i++) begin
      v = 4'(i);
      host_u.wr(OFF_RXVOL, {4'h0, v});
      host_u.wr(OFF_TXVOL, {4'h0, ~v});
      repeat (2) @(posedge core_clk);
      chk(16'(rx_gain_db), gain(v));
      chk(16'(tx_gain_db), gain(~v));
      chk({6'h0, rx_mute, tx_mute, receive_volume_code, transmit_volume_code},
        {6'h0, v == VOL_MUTE, ~v == VOL_MUTE, v, ~v});
    end
    // every pga code, changed only in the initial mode
    for (i = 0; i < 32; i++) begin
      host_u.wr(OFF_APGA, 8'(i));
      host_u.wr(OFF_LPGA, 8'(31 - i));
      repeat (2) @(posedge core_clk);
      chk({4'h0, acoustic_gain_code, acoustic_gain_bad, line_gain_code, line_gain_bad},
        {4'h0, 5'(i), bad(5'(i)), 5'(31 - i), bad(5'(31 - i))});
    end
    // pins OR into the stored bits and show on readback
    p = $random(seed);
    general_inputs_a_high <= p[3:0];
    general_inputs_a_low <= p[7:4];
    alc_bypass_pin_function <= 1'b1;
    host_u.wr(OFF_RXVOL, {4'h0, p[11:8]});
    host_u.wr(OFF_TXVOL, {4'h0, p[15:12]});
    rchk(OFF_RXVOL, {4'h1, p[3:0] | p[11:8]});
    rchk(OFF_TXVOL, {4'h0, p[7:4] | p[15:12]});
    chk({11'h0, alc_bypass, receive_volume_code}, {12'h001, p[3:0] | p[11:8]});
    general_inputs_a_high <= 4'h0;
    general_inputs_a_low <= 4'h0;
    alc_bypass_pin_function <= 1'b0;
    rchk(OFF_RXVOL, {4'h0, p[11:8]});
    chk(16'(alc_bypass), 16'h0);
    host_u.wr(OFF_RXVOL, 8'h10);
    repeat (2) @(posedge core_clk);
    chk(16'(alc_bypass), 16'h1);
    // clock enable low: a write in that cycle is dropped
    ce <= 1'b0;
    host_u.wr(OFF_TXVOL, {4'h0, ~p[15:12]});
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(16'(transmit_volume_code), 16'(p[15:12]));
    // memory word, then the alc maximum gain word
    a = 16'($random(seed)) | 16'h0100;
    d = 16'($random(seed));
    memw(a, d);
    dsp_mem_addr <= a;
    repeat (2) @(posedge core_clk);
    chk(dsp_mem_rdata, d);
    memw(16'h0000, 16'h0015);
    repeat (2) @(posedge core_clk);
    chk(16'(alc_max_gain_db), 16'h15);
    // handover to normal operation
    // canceller enables and output selects live in registers outside this bank
    host_u.wr(OFF_RXVOL, 8'h00);
    host_u.wr(OFF_MODE, 8'h01);
    repeat (3) @(posedge core_clk);
    chk({12'h0, normal_mode, ready_flag, pcm_out_hiz, dsp_enable}, 16'h9);
    rchk(OFF_STATUS, 8'h00);
    rchk(OFF_MODE, 8'h01);
    // in normal operation changes wait for the frame sync
    host_u.wr(OFF_RXVOL, 8'h05);
    repeat (4) @(posedge core_clk);
    chk(16'(receive_volume_code), 16'h0);
    frame_sync <= 1'b1;
    @(posedge core_clk);
    frame_sync <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(16'(receive_volume_code), 16'h5);
    clock_source_select <= 1'b0;
    host_u.wr(OFF_RXVOL, 8'h06);
    repeat (DIV_CYC + 3) @(posedge core_clk);
    chk(16'(receive_volume_code), 16'h6);
    host_u.wr(OFF_MODE, 8'h00);
    repeat (3) @(posedge core_clk);
    chk(16'(ready_flag), 16'h1);
    // second reset with the skip pin high
    skip_init_pin <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({14'h0, normal_mode, ready_flag}, 16'h2);
    complete_run();
  end
endmodule : vdc_regs_test

// File: src/vdc_mem.sv
// vdc_mem: internal data memory, one write port and one registered read port
// assumes the owner never writes and reads the same word in one cycle
`timescale 1ns/1ps
module vdc_mem (
  // clock
  input wire logic core_clk,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [15:0] waddr,
  input wire logic [15:0] wdata,
  // read port
  input wire logic [15:0] raddr,
  output logic [15:0] rdata
);
  // full 64k word space, no reset: contents are set by software
  logic [15:0] mem [0:65535];

  // write and registered read
  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule : vdc_mem

// File: src/vdc_pkg.sv
// vdc_pkg: constants and types for the voice dsp control register bank
// assumes an 8-bit register port and a 125 MHz core clock
package vdc_pkg;
  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_MEMWR = 8'h01;
  localparam logic [7:0] OFF_RXVOL = 8'h02;
  localparam logic [7:0] OFF_TXVOL = 8'h03;
  localparam logic [7:0] OFF_APGA = 8'h04;
  localparam logic [7:0] OFF_LPGA = 8'h05;
  localparam logic [7:0] OFF_MADRH = 8'h06;
  localparam logic [7:0] OFF_MADRL = 8'h07;
  localparam logic [7:0] OFF_MDATH = 8'h08;
  localparam logic [7:0] OFF_MDATL = 8'h09;
  localparam logic [7:0] OFF_STATUS = 8'h0a;
  // field positions
  localparam int BIT_OPMODE = 0;
  localparam int BIT_MEMWR = 7;
  localparam int BIT_ALCBYP = 4;
  localparam int BIT_READY = 7;
  // reset value of the plain control fields
  localparam logic [7:0] RST_CTRL = 8'h00;
  // mute code of the volume fields
  localparam logic [3:0] VOL_MUTE = 4'h8;
  // timing
  localparam int CLK_KHZ = 125000;
  localparam int INIT_WAIT_MS = 250;
  localparam int INIT_WAIT_CYC = INIT_WAIT_MS * CLK_KHZ;
  localparam int SYNC_HZ = 8000;
  localparam int SYNC_DIV_CYC = (CLK_KHZ * 1000) / SYNC_HZ;
  localparam logic [2:0] XFER_CYC = 3'h4;
  // receive alc figures
  localparam int ALC_TARGET_DBM0 = -10;
  localparam logic [5:0] ALC_MAXGAIN_DEF = 6'h1b;
  // operating states
  typedef enum logic [1:0] {VDC_WAIT, VDC_INIT, VDC_NORM} vdc_state_t;
endpackage : vdc_pkg

// File: src/vdc_regs.sv
// vdc_regs: control register bank of the hands-free voice processor
// assumes a plain register port and a frame sync synchronous to core_clk
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module vdc_regs #(
  parameter int INIT_WAIT_CYCLES = vdc_pkg::INIT_WAIT_CYC,
  parameter int SYNC_DIV_CYCLES = vdc_pkg::SYNC_DIV_CYC,
  parameter logic [15:0] ALC_MAXGAIN_ADDR = 16'h0000,
  // version values below are arbitrary
  parameter logic [15:0] VER_ADDR = 16'h5a01,
  parameter logic [15:0] VER_DATA = 16'h0001
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic [vdc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [vdc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [vdc_pkg::DATA_W-1:0] reg_rdata,
  // pins
  input wire logic skip_init_pin,
  input wire logic clock_source_select,
  input wire logic frame_sync,
  input wire logic alc_bypass_pin_function,
  input wire logic [3:0] general_inputs_a_high,
  input wire logic [3:0] general_inputs_a_low,
  // mode outputs
  output logic ready_flag,
  output logic normal_mode,
  output logic pcm_out_hiz,
  output logic speech_in_idle,
  output logic dsp_enable,
  // processing controls
  output logic alc_bypass,
  output logic [5:0] alc_max_gain_db,
  output logic [3:0] receive_volume_code,
  output logic [3:0] transmit_volume_code,
  output logic rx_mute,
  output logic tx_mute,
  output logic signed [5:0] rx_gain_db,
  output logic signed [5:0] tx_gain_db,
  output logic [4:0] acoustic_gain_code,
  output logic [4:0] line_gain_code,
  output logic acoustic_gain_bad,
  output logic line_gain_bad,
  // dsp side memory read
  input wire logic [15:0] dsp_mem_addr,
  output logic [15:0] dsp_mem_rdata
);
  import vdc_pkg::*;

  // whole state of the bank
  typedef struct packed {
    vdc_state_t state;
    logic [24:0] wait_cnt;   // power-up delay
    logic [13:0] sync_cnt;   // internal sync divider
    logic mode_bit;          // operation mode bit
    logic busy;              // mem_write_execute
    logic [2:0] xfer_cnt;    // transfer length
    logic mem_we;            // memory write strobe
    logic alc_byp;           // alc_bypass_bit
    logic [3:0] rx_vol;      // receive_volume_code
    logic [3:0] tx_vol;      // transmit_volume_code
    logic [4:0] apga;        // acoustic_gain_code
    logic [4:0] lpga;        // line_gain_code
    logic [15:0] madr;       // memory address
    logic [15:0] mdat;       // memory data
    logic [7:0] rdata;       // read data
    logic e_alc;             // effective copies
    logic [3:0] e_rx;
    logic [3:0] e_tx;
    logic [4:0] e_apga;
    logic [4:0] e_lpga;
    logic signed [5:0] rx_db;
    logic signed [5:0] tx_db;
    logic [5:0] alc_max;
  } vdc_st_t;

  vdc_st_t s_reg;
  vdc_st_t s_next;

  // pin ORed views of the loose bits
  logic alc_or;
  logic [3:0] rx_or;
  logic [3:0] tx_or;
  logic sync_tick;
  logic trig;
  assign alc_or = s_reg.alc_byp | alc_bypass_pin_function;
  assign rx_or = s_reg.rx_vol | general_inputs_a_high;
  assign tx_or = s_reg.tx_vol | general_inputs_a_low;
  // external sync unless the internal clock mode is chosen
  assign sync_tick = clock_source_select ? frame_sync : (s_reg.sync_cnt == 14'h0000);
  assign trig = reg_wr && (reg_addr == OFF_MEMWR) && reg_wdata[BIT_MEMWR] && !s_reg.busy;

  // next state
  always_comb begin
    s_next = s_reg;
    s_next.mem_we = 1'b0;
    // free-running internal sync
    if (s_reg.sync_cnt == 14'h0000) begin
      s_next.sync_cnt = 14'(SYNC_DIV_CYCLES - 1);
    end else begin
      s_next.sync_cnt = s_reg.sync_cnt - 14'h0001;
    end
    // mode sequencing
    case (s_reg.state)
      VDC_WAIT: begin
        if (skip_init_pin) begin
          s_next.state = VDC_NORM;
          s_next.mode_bit = 1'b1;
        end else if (s_reg.wait_cnt == 25'(INIT_WAIT_CYCLES - 1)) begin
          s_next.state = VDC_INIT;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt + 25'h0000001;
        end
      end
      VDC_INIT: begin
        if (s_reg.mode_bit) begin
          s_next.state = VDC_NORM;
        end
      end
      VDC_NORM: begin
        if (!s_reg.mode_bit) begin
          s_next.state = VDC_INIT;
        end
      end
      default: begin
        s_next.state = VDC_WAIT;
      end
    endcase
    // register writes; reserved bits are not stored
    if (reg_wr) begin
      if (reg_addr == OFF_MODE) begin
        // a skip at reset release wins over a clearing write in the same cycle
        s_next.mode_bit = reg_wdata[BIT_OPMODE] ||
                          ((s_reg.state == VDC_WAIT) && skip_init_pin);
      end else if (reg_addr == OFF_RXVOL) begin
        s_next.alc_byp = reg_wdata[BIT_ALCBYP];
        s_next.rx_vol = reg_wdata[3:0];
      end else if (reg_addr == OFF_TXVOL) begin
        s_next.tx_vol = reg_wdata[3:0];
      end else if (reg_addr == OFF_APGA) begin
        s_next.apga = reg_wdata[4:0];
      end else if (reg_addr == OFF_LPGA) begin
        s_next.lpga = reg_wdata[4:0];
      end else if (reg_addr == OFF_MADRH) begin
        s_next.madr[15:8] = reg_wdata;
      end else if (reg_addr == OFF_MADRL) begin
        s_next.madr[7:0] = reg_wdata;
      end else if (reg_addr == OFF_MDATH) begin
        s_next.mdat[15:8] = reg_wdata;
      end else if (reg_addr == OFF_MDATL) begin
        s_next.mdat[7:0] = reg_wdata;
      end
    end
    // memory write: trigger, strobe next cycle, then hold busy
    if (trig) begin
      s_next.busy = 1'b1;
      s_next.mem_we = 1'b1;
      s_next.xfer_cnt = XFER_CYC - 3'h1;
    end else if (s_reg.busy) begin
      if (s_reg.xfer_cnt == 3'h0) begin
        s_next.busy = 1'b0;
      end else begin
        s_next.xfer_cnt = s_reg.xfer_cnt - 3'h1;
      end
    end
    // a write to the alc gain word also updates the live maximum
    if (s_reg.mem_we && (s_reg.madr == ALC_MAXGAIN_ADDR)) begin
      s_next.alc_max = s_reg.mdat[5:0];
    end
    // effective controls follow the frame sync in normal mode only
    if (sync_tick || (s_reg.state != VDC_NORM)) begin
      s_next.e_alc = alc_or;
      s_next.e_rx = rx_or;
      s_next.e_tx = tx_or;
      s_next.e_apga = s_reg.apga;
      s_next.e_lpga = s_reg.lpga;
      s_next.rx_db = 6'(signed'({{2{rx_or[3]}}, rx_or}) * 6'sd3);
      s_next.tx_db = 6'(signed'({{2{tx_or[3]}}, tx_or}) * 6'sd3);
    end
    // read data, one cycle after the strobe
    s_next.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == OFF_MODE) begin
        s_next.rdata = {7'h00, s_reg.mode_bit};
      end else if (reg_addr == OFF_MEMWR) begin
        s_next.rdata = {s_reg.busy, 7'h00};
      end else if (reg_addr == OFF_RXVOL) begin
        s_next.rdata = {3'h0, alc_or, rx_or};
      end else if (reg_addr == OFF_TXVOL) begin
        s_next.rdata = {4'h0, tx_or};
      end else if (reg_addr == OFF_APGA) begin
        s_next.rdata = {3'h0, s_reg.apga};
      end else if (reg_addr == OFF_LPGA) begin
        s_next.rdata = {3'h0, s_reg.lpga};
      end else if (reg_addr == OFF_MADRH) begin
        s_next.rdata = s_reg.madr[15:8];
      end else if (reg_addr == OFF_MADRL) begin
        s_next.rdata = s_reg.madr[7:0];
      end else if (reg_addr == OFF_MDATH) begin
        s_next.rdata = s_reg.mdat[15:8];
      end else if (reg_addr == OFF_MDATL) begin
        s_next.rdata = s_reg.mdat[7:0];
      end else if (reg_addr == OFF_STATUS) begin
        s_next.rdata = {(s_reg.state == VDC_INIT), 7'h00};
      end
    end
  end

  // state register; synchronous reset is the power-down reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.state <= VDC_WAIT;
      s_reg.madr <= VER_ADDR;
      s_reg.mdat <= VER_DATA;
      s_reg.alc_max <= ALC_MAXGAIN_DEF;
      s_reg.alc_byp <= RST_CTRL[BIT_ALCBYP];
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // internal data memory; the dsp reads coefficients from it
  vdc_mem u_mem (
    .core_clk(core_clk),
    .ce(ce),
    .we(s_reg.mem_we),
    .waddr(s_reg.madr),
    .wdata(s_reg.mdat),
    .raddr(dsp_mem_addr),
    .rdata(dsp_mem_rdata)
  );

  // outputs; initial mode gates processing off
  assign ready_flag = (s_reg.state == VDC_INIT);
  assign normal_mode = (s_reg.state == VDC_NORM);
  assign pcm_out_hiz = !normal_mode;
  assign speech_in_idle = !normal_mode;
  assign dsp_enable = normal_mode;
  assign alc_bypass = s_reg.e_alc;
  assign alc_max_gain_db = s_reg.alc_max;
  assign receive_volume_code = s_reg.e_rx;
  assign transmit_volume_code = s_reg.e_tx;
  assign rx_mute = (s_reg.e_rx == VOL_MUTE);
  assign tx_mute = (s_reg.e_tx == VOL_MUTE);
  assign rx_gain_db = s_reg.rx_db;
  assign tx_gain_db = s_reg.tx_db;
  assign acoustic_gain_code = s_reg.e_apga;
  assign line_gain_code = s_reg.e_lpga;
  // legal pga range is -10..+10 steps of 2 dB
  assign acoustic_gain_bad = (signed'(s_reg.e_apga) > 5'sd10) ||
                             (signed'(s_reg.e_apga) < -5'sd10);
  assign line_gain_bad = (signed'(s_reg.e_lpga) > 5'sd10) ||
                         (signed'(s_reg.e_lpga) < -5'sd10);
  assign reg_rdata = s_reg.rdata;

  // checks; all but AST_VER and the COV_ covers disabled while frozen by ce
  AST_WAIT_TO_INIT: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    (s_reg.state == VDC_WAIT) && !skip_init_pin &&
    (s_reg.wait_cnt == 25'(INIT_WAIT_CYCLES - 1)) |=> ready_flag)
    else $error("initial mode not entered after wait");
  AST_INIT_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    ready_flag |-> pcm_out_hiz && speech_in_idle && !dsp_enable)
    else $error("processing active in initial mode");
  AST_SKIP: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    !$past(rst_n) && skip_init_pin |=> normal_mode && !ready_flag)
    else $error("skip pin did not bypass initial mode");
  AST_GO_NORMAL: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    ready_flag && reg_wr && (reg_addr == OFF_MODE) && reg_wdata[0] |=> ##1
    (normal_mode && !ready_flag))
    else $error("mode bit did not start normal operation");
  AST_MEMWR: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    trig |=> s_reg.mem_we && s_reg.busy &&
    (s_reg.madr == $past(s_reg.madr)))
    else $error("memory write strobe missing");
  AST_BUSY_LEN: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    trig |=> s_reg.busy [*4] ##1 !s_reg.busy)
    else $error("execute bit held wrong length");
  AST_ALC_OR: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    reg_rd && (reg_addr == OFF_RXVOL) && alc_bypass_pin_function |=> reg_rdata[4])
    else $error("alc bypass readback ignores pin");
  AST_RX_OR: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    reg_rd && (reg_addr == OFF_RXVOL) |=>
    ((reg_rdata[3:0] & $past(general_inputs_a_high)) == $past(general_inputs_a_high)))
    else $error("receive volume readback ignores pins");
  AST_TX_OR: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    reg_rd && (reg_addr == OFF_TXVOL) |=>
    ((reg_rdata[3:0] & $past(general_inputs_a_low)) == $past(general_inputs_a_low)))
    else $error("transmit volume readback ignores pins");
  AST_RX_GAIN: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    !rx_mute |-> (rx_gain_db == 6'(signed'({{2{receive_volume_code[3]}},
    receive_volume_code}) * 6'sd3)))
    else $error("receive gain mismatch");
  AST_APGA: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    (acoustic_gain_code == 5'h0b) || (acoustic_gain_code == 5'h15) |-> acoustic_gain_bad)
    else $error("prohibited acoustic code not flagged");
  AST_LPGA: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    (line_gain_code == 5'h0a) || (line_gain_code == 5'h16) |-> !line_gain_bad)
    else $error("legal line code flagged");
  AST_ADDR: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    reg_wr && (reg_addr == OFF_MADRH) |=> (s_reg.madr[15:8] == $past(reg_wdata)))
    else $error("upper address byte not stored");
  AST_VER: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(rst_n) |-> (s_reg.madr == VER_ADDR) && (s_reg.mdat == VER_DATA))
    else $error("version value missing after reset");
  AST_SYNC: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
    normal_mode && $past(normal_mode) && !$past(sync_tick) && $past(ce) |->
    $stable(receive_volume_code))
    else $error("volume changed between syncs");
  COV_INIT: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(ready_flag));
  COV_NORM: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(normal_mode));
  COV_MEMWR: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(s_reg.busy));
  COV_MUTE: cover property (@(posedge core_clk) disable iff (!rst_n) rx_mute && normal_mode);
endmodule : vdc_regs
